// ### verilog/pma_top.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Each of four channels takes two one-bit occupancy inputs following the sensors.
// - Non-inverted polarity reads an open contact as vacant and closed as occupied.
// - Inverted polarity reads an open contact as occupied and closed as vacant.
// - Handling is selectable as comfort extension, comfort limitation or both.
// - Extension holds comfort while occupied even when the schedule drops it.
// - Extension keeps comfort through short vacancy and follows the schedule once it is long.
// - Occupancy seen outside comfort changes nothing until the next scheduled comfort.
// - Limitation drops comfort to an attenuated mode after vacancy longer than a set time.
// - The attenuated mode is its own setting, independent of the schedule.
// - A supervisor forced mode beats any occupancy-derived mode.
// - An open window forces building protection over every other source.
// - Occupancy handling works only when the integrated controller is configured.
// - Closing a channel's window restores the mode that would otherwise be in effect on that channel.
module pma_top #(
    parameter int NCH = pma_pkg::NCH,
    parameter int TICK_CYC = pma_pkg::TICK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2*NCH-1:0] occupancy_in,
    input wire logic [NCH-1:0] window_open,
    output logic [2*NCH-1:0] mode_out
);
    // CTRL: [0] controller enable, [8+2i] invert pair, per channel handling at [16+2i],
    // attenuation at [24+2i]
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;
    logic [15:0] time_r;
    logic [15:0] time_nxt;
    // INPUT: schedule [2i+1:2i], forced mode [8+2i+1:8+2i], force valid [16+i]
    logic [31:0] inp_r;
    logic [31:0] inp_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [2*NCH-1:0] s1_r;
    logic [2*NCH-1:0] s2_r;
    logic [2*NCH-1:0] s3_r;
    logic [2*NCH-1:0] occ_pin_r;
    logic [2*NCH-1:0] occ_pin_nxt;
    logic [NCH-1:0] w1_r;
    logic [NCH-1:0] w2_r;
    logic [NCH-1:0] w3_r;
    logic [NCH-1:0] win_r;
    logic [NCH-1:0] win_nxt;
    logic [23:0] tcnt_r;
    logic [23:0] tcnt_nxt;
    logic tick;
    logic [NCH-1:0] occ;
    logic [2*NCH-1:0] ch_mode;
    logic [2*NCH-1:0] out_r;
    logic [2*NCH-1:0] out_nxt;
    logic wr;
    logic rd;
    logic bad;

    always_comb begin
        wr = psel && penable && pwrite;
        rd = psel && !penable && !pwrite;
        bad = !(paddr == pma_pkg::ADDR_CTRL || paddr == pma_pkg::ADDR_TIME
            || paddr == pma_pkg::ADDR_INPUT || paddr == pma_pkg::ADDR_STAT
            || paddr == pma_pkg::ADDR_OCC) || paddr[1:0] != 2'b00;
        ctrl_nxt = ctrl_r;
        time_nxt = time_r;
        inp_nxt = inp_r;
        if (wr && !bad) begin
            unique case (paddr)
                pma_pkg::ADDR_CTRL: ctrl_nxt = pwdata;
                pma_pkg::ADDR_TIME: time_nxt = pwdata[15:0];
                pma_pkg::ADDR_INPUT: inp_nxt = pwdata;
                default: ;
            endcase
        end
        rdata_nxt = rdata_r;
        if (rd) begin
            unique case (paddr)
                pma_pkg::ADDR_CTRL: rdata_nxt = ctrl_r;
                pma_pkg::ADDR_TIME: rdata_nxt = {16'h0000, time_r};
                pma_pkg::ADDR_INPUT: rdata_nxt = inp_r;
                pma_pkg::ADDR_STAT: rdata_nxt = {24'h000000, out_r};
                pma_pkg::ADDR_OCC: rdata_nxt = {20'h00000, win_r, 4'h0, occ};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && bad;
    assign prdata = rdata_r;

    // Millisecond tick for the vacancy timers
    always_comb begin
        tick = tcnt_r == 24'(TICK_CYC - 1);
        tcnt_nxt = tick ? 24'h000000 : tcnt_r + 24'h000001;
    end

    // Pin change counts only once two later stages agree
    always_comb begin
        occ_pin_nxt = occ_pin_r;
        win_nxt = win_r;
        for (int i = 0; i < 2*NCH; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                occ_pin_nxt[i] = s3_r[i];
            end
        end
        for (int i = 0; i < NCH; i++) begin
            if (w2_r[i] == w3_r[i]) begin
                win_nxt[i] = w3_r[i];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            // Closed contact reads 1; invert flips the sense per pair
            occ[i] = (occ_pin_r[2*i] ^ ctrl_r[8+2*i])
                || (occ_pin_r[2*i+1] ^ ctrl_r[8+2*i]);
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : gch
            pma_chan_if cif ();
            assign cif.occ = occ[g];
            assign cif.tick = tick;
            assign cif.enable = ctrl_r[0];
            assign cif.handling = ctrl_r[16+2*g +: 2];
            assign cif.atten = ctrl_r[24+2*g +: 2];
            assign cif.sched = inp_r[2*g +: 2];
            assign cif.limit = time_r;
            assign ch_mode[2*g +: 2] = cif.mode;
            pma_chan u_chan (
                .pclk(pclk),
                .presetn(presetn),
                .c(cif.chan)
            );
        end
    endgenerate

    // Window first, then supervisor, then occupancy result; nothing stored across protection
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            if (win_r[i]) begin
                out_nxt[2*i +: 2] = pma_pkg::PMA_PROTECT;
            end else if (inp_r[16+i]) begin
                out_nxt[2*i +: 2] = inp_r[8+2*i +: 2];
            end else begin
                out_nxt[2*i +: 2] = ch_mode[2*i +: 2];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= pma_pkg::CTRL_RST;
            time_r <= pma_pkg::TIME_RST;
            inp_r <= 32'h0000_0000;
            rdata_r <= 32'h0000_0000;
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            occ_pin_r <= '0;
            w1_r <= '0;
            w2_r <= '0;
            w3_r <= '0;
            win_r <= '0;
            tcnt_r <= 24'h000000;
            out_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
            time_r <= time_nxt;
            inp_r <= inp_nxt;
            rdata_r <= rdata_nxt;
            s1_r <= occupancy_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            occ_pin_r <= occ_pin_nxt;
            w1_r <= window_open;
            w2_r <= w1_r;
            w3_r <= w2_r;
            win_r <= win_nxt;
            tcnt_r <= tcnt_nxt;
            out_r <= out_nxt;
        end
    end

    assign mode_out = out_r;

    property p_window;
        @(posedge pclk) disable iff (!presetn)
        win_r[0] |=> mode_out[1:0] == pma_pkg::PMA_PROTECT;
    endproperty
    a_window: assert property (p_window) else $error("window not protecting");

    property p_force;
        @(posedge pclk) disable iff (!presetn)
        (!win_r[0] && inp_r[16]) |=> mode_out[1:0] == $past(inp_r[9:8]);
    endproperty
    a_force: assert property (p_force) else $error("forced mode ignored");

    property p_restore;
        @(posedge pclk) disable iff (!presetn)
        ($fell(win_r[0]) && !inp_r[16]) |=> mode_out[1:0] == $past(ch_mode[1:0]);
    endproperty
    a_restore: assert property (p_restore) else $error("mode not restored");

    property p_occ;
        @(posedge pclk) disable iff (!presetn)
        occ[0] == ((occ_pin_r[0] || occ_pin_r[1]) ^ ctrl_r[8])
            || (occ_pin_r[0] != occ_pin_r[1]);
    endproperty
    a_occ: assert property (p_occ) else $error("occupancy mismatch");

    property p_sync;
        @(posedge pclk) disable iff (!presetn)
        (s2_r[0] == s3_r[0]) |=> occ_pin_r[0] == $past(s3_r[0]);
    endproperty
    a_sync: assert property (p_sync) else $error("input not taken");

    property p_wr_ctrl;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == pma_pkg::ADDR_CTRL) |=> ctrl_r == $past(pwdata);
    endproperty
    a_wr_ctrl: assert property (p_wr_ctrl) else $error("control write lost");

    property p_wr_time;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == pma_pkg::ADDR_TIME)
            |=> time_r == $past(pwdata[15:0]);
    endproperty
    a_wr_time: assert property (p_wr_time) else $error("time write lost");

    property p_wr_input;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == pma_pkg::ADDR_INPUT) |=> inp_r == $past(pwdata);
    endproperty
    a_wr_input: assert property (p_wr_input) else $error("input write lost");

    // A refused write must leave every setting alone
    property p_wr_bad;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && pslverr) |=> ctrl_r == $past(ctrl_r)
            && time_r == $past(time_r) && inp_r == $past(inp_r);
    endproperty
    a_wr_bad: assert property (p_wr_bad) else $error("refused write changed state");

    property p_rd_stat;
        @(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && paddr == pma_pkg::ADDR_STAT)
            |=> prdata == {24'h000000, $past(mode_out)};
    endproperty
    a_rd_stat: assert property (p_rd_stat) else $error("status read wrong");

    property p_rd_keep;
        @(posedge pclk) disable iff (!presetn)
        !(psel && !penable && !pwrite) |=> $stable(prdata);
    endproperty
    a_rd_keep: assert property (p_rd_keep) else $error("read data moved");

    // Only valid while the tick divider is longer than one cycle
    property p_tick_gap;
        @(posedge pclk) disable iff (!presetn)
        tick |=> !tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick too frequent");

    property p_win_sync;
        @(posedge pclk) disable iff (!presetn)
        (w2_r[0] == w3_r[0]) |=> win_r[0] == $past(w3_r[0]);
    endproperty
    a_win_sync: assert property (p_win_sync) else $error("window not taken");

    property p_pin_hold;
        @(posedge pclk) disable iff (!presetn)
        (s2_r[0] != s3_r[0]) |=> occ_pin_r[0] == $past(occ_pin_r[0]);
    endproperty
    a_pin_hold: assert property (p_pin_hold) else $error("unsettled pin taken");

    property p_follow;
        @(posedge pclk) disable iff (!presetn)
        (!win_r[0] && !inp_r[16]) |=> mode_out[1:0] == $past(ch_mode[1:0]);
    endproperty
    a_follow: assert property (p_follow) else $error("occupancy mode not passed");

    property p_window3;
        @(posedge pclk) disable iff (!presetn)
        win_r[3] |=> mode_out[7:6] == pma_pkg::PMA_PROTECT;
    endproperty
    a_window3: assert property (p_window3) else $error("last window not protecting");

    property p_force3;
        @(posedge pclk) disable iff (!presetn)
        (!win_r[3] && inp_r[19]) |=> mode_out[7:6] == $past(inp_r[15:14]);
    endproperty
    a_force3: assert property (p_force3) else $error("last forced mode ignored");

    c_win: cover property (@(posedge pclk) disable iff (!presetn) $fell(win_r[0]));
    c_force: cover property (@(posedge pclk) disable iff (!presetn) inp_r[16] && !win_r[0]);
endmodule
`default_nettype wire

// ### verilog/pma_pkg.sv
`default_nettype none
package pma_pkg;
    localparam int NCH = 4;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TIME = 8'h04;
    localparam logic [7:0] ADDR_INPUT = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_OCC = 8'h10;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] TIME_RST = 16'h0064;
    localparam int TICK_NS = 1000000;
    localparam int CLK_NS = 100;
    localparam int TICK_CYC = TICK_NS / CLK_NS;
    typedef enum logic [1:0] {
        PMA_COMFORT = 2'b00,
        PMA_STANDBY = 2'b01,
        PMA_ECONOMY = 2'b10,
        PMA_PROTECT = 2'b11
    } pma_mode_t;
    typedef enum logic [1:0] {
        PMA_HND_OFF = 2'b00,
        PMA_HND_EXT = 2'b01,
        PMA_HND_LIM = 2'b10,
        PMA_HND_BOTH = 2'b11
    } pma_hnd_t;
endpackage
`default_nettype wire

// ### verilog/pma_chan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pma_chan_if;
    logic occ;
    logic tick;
    logic enable;
    logic [1:0] handling;
    logic [1:0] atten;
    logic [1:0] sched;
    logic [15:0] limit;
    logic [1:0] mode;
    modport top (output occ, tick, enable, handling, atten, sched, limit, input mode);
    modport chan (input occ, tick, enable, handling, atten, sched, limit, output mode);
endinterface
`default_nettype wire

// ### verilog/pma_chan.sv
`timescale 1ns/1ps
`default_nettype none
module pma_chan (
    input wire logic pclk,
    input wire logic presetn,
    pma_chan_if.chan c
);
    logic hold_r;
    logic hold_nxt;
    logic lim_r;
    logic lim_nxt;
    logic [15:0] vac_r;
    logic [15:0] vac_nxt;
    logic [1:0] mode_r;
    logic [1:0] mode_nxt;
    logic ext_on;
    logic lim_on;
    logic expired;

    always_comb begin
        ext_on = c.enable && (c.handling == pma_pkg::PMA_HND_EXT
            || c.handling == pma_pkg::PMA_HND_BOTH);
        lim_on = c.enable && (c.handling == pma_pkg::PMA_HND_LIM
            || c.handling == pma_pkg::PMA_HND_BOTH);
        expired = vac_r >= c.limit;
        vac_nxt = vac_r;
        if (c.occ || mode_r != pma_pkg::PMA_COMFORT) begin
            vac_nxt = '0;
        end else if (c.tick && !expired) begin
            vac_nxt = vac_r + 16'h0001;
        end
        hold_nxt = hold_r;
        lim_nxt = lim_r;
        // Extension only latches while comfort is already running
        if (!ext_on || c.sched == pma_pkg::PMA_COMFORT) begin
            hold_nxt = 1'b0;
        end else if (mode_r == pma_pkg::PMA_COMFORT && c.occ && !expired) begin
            hold_nxt = 1'b1;
        end else if (expired && !c.occ) begin
            hold_nxt = 1'b0;
        end
        // Limitation cleared only when the schedule leaves comfort or limitation is switched off
        if (!lim_on || c.sched != pma_pkg::PMA_COMFORT) begin
            lim_nxt = 1'b0;
        end else if (mode_r == pma_pkg::PMA_COMFORT && !c.occ && expired) begin
            lim_nxt = 1'b1;
        end
        if (lim_nxt) begin
            mode_nxt = c.atten;
        end else if (hold_nxt) begin
            mode_nxt = pma_pkg::PMA_COMFORT;
        end else begin
            mode_nxt = c.sched;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_r <= 1'b0;
            lim_r <= 1'b0;
            vac_r <= '0;
            mode_r <= pma_pkg::PMA_COMFORT;
        end else begin
            hold_r <= hold_nxt;
            lim_r <= lim_nxt;
            vac_r <= vac_nxt;
            mode_r <= mode_nxt;
        end
    end

    assign c.mode = mode_r;

    property p_lim_atten;
        @(posedge pclk) disable iff (!presetn)
        lim_r |-> mode_r == $past(c.atten);
    endproperty
    a_lim_atten: assert property (p_lim_atten) else $error("limited mode not attenuated");

    property p_hold_comfort;
        @(posedge pclk) disable iff (!presetn)
        (hold_r && !lim_r) |-> mode_r == pma_pkg::PMA_COMFORT;
    endproperty
    a_hold_comfort: assert property (p_hold_comfort) else $error("hold lost comfort");

    property p_no_start_hold;
        @(posedge pclk) disable iff (!presetn)
        ($past(mode_r) != pma_pkg::PMA_COMFORT && !$past(hold_r)) |-> !hold_r;
    endproperty
    a_no_start_hold: assert property (p_no_start_hold) else $error("hold from non comfort");

    property p_disabled;
        @(posedge pclk) disable iff (!presetn)
        !c.enable |=> !hold_r && !lim_r;
    endproperty
    a_disabled: assert property (p_disabled) else $error("occupancy active while off");

    c_hold: cover property (@(posedge pclk) disable iff (!presetn) hold_r ##1 !hold_r);
    c_lim: cover property (@(posedge pclk) disable iff (!presetn) $rose(lim_r));
endmodule
`default_nettype wire

// ### dv/pma_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module pma_sensor_model (
    input wire logic pclk,
    input wire logic [7:0] presence,
    input wire logic [3:0] nc_type,
    input wire logic [3:0] win_req,
    output logic [7:0] contact,
    output logic [3:0] window_open
);
    // Bus-fed sensor objects refresh on the clock, so levels arrive one edge late
    always_ff @(posedge pclk) begin
        for (int i = 0; i < 8; i++) begin
            contact[i] <= nc_type[i/2] ? presence[i] : ~presence[i];
        end
        window_open <= win_req;
    end
endmodule
`default_nettype wire

// ### dv/presence_mode_arbiter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module presence_mode_arbiter_tb;
    localparam int TC = 10;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr, occ_w, pres, mode_out;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] win_w, nct, winr;
    int bad_count, checked, en, tlim;
    int sch[4], frc[4], fv[4], hnd[4], att[4], inv[4], vac[4], held[4], lmt[4];
    pma_top #(.TICK_CYC(TC)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .occupancy_in(occ_w),
        .window_open(win_w), .mode_out(mode_out));
    pma_sensor_model sens (.pclk(pclk), .presence(pres), .nc_type(nct), .win_req(winr),
        .contact(occ_w), .window_open(win_w));
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    task test_done();
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task cmp_reg(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %0t reg got %h exp %h", $time, g, e);
        end
    endtask
    task cmp_mode(input int c, input logic [1:0] g, input logic [1:0] e);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %0t mode ch %0d got %h exp %h", $time, c, g, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic occ(int c);
        return (occ_w[2*c] ^ inv[c][0]) | (occ_w[2*c+1] ^ inv[c][0]);
    endfunction
    function automatic void upd();
        for (int c = 0; c < 4; c++) begin
            if (occ(c) === 1'b1) vac[c] = 0;
            held[c] = en && hnd[c][0] && ((occ(c) && sch[c] == 0) || (held[c] && vac[c] < tlim));
            lmt[c] = en && hnd[c][1] && sch[c] == 0 && (lmt[c] || vac[c] > tlim);
        end
    endfunction
    function automatic logic [1:0] exp_mode(int c);
        if (winr[c]) return 2'h3;
        if (fv[c] != 0) return frc[c][1:0];
        if (lmt[c] != 0) return att[c][1:0];
        if (held[c] != 0) return 2'h0;
        return sch[c][1:0];
    endfunction
    // Vacancy is counted in whole ticks, as the design's timer does
    task wait_ms(input int n);
        repeat (n) begin
            repeat (TC) @(posedge pclk);
            for (int c = 0; c < 4; c++) if (occ(c) !== 1'b1) vac[c]++;
            upd();
        end
    endtask
    task cfg();
        logic [31:0] w;
        w = 32'(en);
        for (int c = 0; c < 4; c++) begin
            w[8+2*c] = inv[c][0];
            w[16+2*c+:2] = hnd[c][1:0];
            w[24+2*c+:2] = att[c][1:0];
        end
        apb(1'b1, pma_pkg::ADDR_CTRL, w);
        w = 32'h0;
        for (int c = 0; c < 4; c++) begin
            w[2*c+:2] = sch[c][1:0];
            w[8+2*c+:2] = frc[c][1:0];
            w[16+c] = fv[c][0];
        end
        apb(1'b1, pma_pkg::ADDR_INPUT, w);
        apb(1'b1, pma_pkg::ADDR_TIME, 32'(tlim));
        upd();
    endtask
    task chk();
        logic [31:0] e;
        logic [31:0] o;
        repeat (8) @(posedge pclk);
        @(negedge pclk);
        e = 32'h0;
        o = 32'h0;
        for (int c = 0; c < 4; c++) begin
            cmp_mode(c, mode_out[2*c+:2], exp_mode(c));
            e[2*c+:2] = exp_mode(c);
            o[c] = occ(c);
            o[8+c] = winr[c];
        end
        @(posedge pclk);
        apb(1'b0, pma_pkg::ADDR_STAT, 32'h0);
        cmp_reg(rd, e);
        apb(1'b0, pma_pkg::ADDR_OCC, 32'h0);
        cmp_reg(rd, o);
    endtask
    initial begin
        #2_000_000;
        bad_count++;
        test_done();
    end
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pres = 8'h00;
        nct = 4'hF;
        winr = 4'h0;
        presetn = 1'b0;
        tlim = 100;
        rd = $urandom(32'h77C68667);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, pma_pkg::ADDR_CTRL, 32'h0);
        cmp_reg(rd, pma_pkg::CTRL_RST);
        apb(1'b0, pma_pkg::ADDR_TIME, 32'h0);
        cmp_reg(rd, {16'h0, pma_pkg::TIME_RST});
        apb(1'b1, 8'h14, 32'hFFFF_FFFF);
        cmp_reg({31'h0, er}, 32'h1);
        apb(1'b0, 8'h02, 32'h0);
        cmp_reg({er, rd[30:0]}, 32'h8000_0000);
        en = 1;
        repeat (8) begin
            pres <= 8'($urandom);
            nct <= 4'($urandom);
            winr <= 4'($urandom);
            for (int c = 0; c < 4; c++) begin
                inv[c] = $urandom % 2;
                sch[c] = $urandom % 3;
            end
            cfg();
            chk();
        end
        winr <= 4'h0;
        nct <= 4'hF;
        pres <= 8'h00;
        en = 0;
        tlim = 20;
        for (int c = 0; c < 4; c++) begin
            inv[c] = 0;
            sch[c] = 0;
            hnd[c] = 3;
            att[c] = 1;
        end
        cfg();
        wait_ms(40);
        chk();
        pres <= 8'hFF;
        wait_ms(1);
        en = 1;
        for (int c = 0; c < 4; c++) hnd[c] = (c + 1) % 4;
        att[1] = 2;
        cfg();
        wait_ms(1);
        chk();
        for (int c = 0; c < 4; c++) sch[c] = 2;
        cfg();
        chk();
        pres <= 8'h00;
        wait_ms(6);
        chk();
        wait_ms(40);
        chk();
        for (int c = 0; c < 4; c++) sch[c] = 1;
        pres <= 8'hFF;
        cfg();
        chk();
        for (int c = 0; c < 4; c++) sch[c] = 0;
        cfg();
        wait_ms(2);
        pres <= 8'h00;
        wait_ms(40);
        chk();
        fv[0] = 1;
        frc[0] = 1;
        fv[1] = 1;
        frc[1] = 1;
        cfg();
        chk();
        winr <= 4'h3;
        chk();
        winr <= 4'h0;
        chk();
        test_done();
    end
endmodule
`default_nettype wire
